// *** rtl/ecd_pkg.sv ***
/*
 * Shared constants and types for the three-unit counter/delay block:
 * configuration layout, clock-source and edge codes, register offsets,
 * reset values and timing figures.
 * Assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package ecd_pkg;

   // count width of one unit
   localparam int CNT_W = 8;

   // one unit's configuration, bit 0 is the mode bit
   typedef struct packed {
      logic [1:0] edge_sel;   // delay/reset edge treatment
      logic [7:0] ctrl;       // count length / delay control value
      logic [2:0] clk_sel;    // count clock source
      logic mode;             // 0 delay, 1 counter
   } ecd_cfg_type;

   localparam int CFG_W = 14;

   // clock source codes
   localparam logic [2:0] CLK_RC = 3'h0;
   localparam logic [2:0] CLK_DIV4 = 3'h1;
   localparam logic [2:0] CLK_DIV12 = 3'h2;
   localparam logic [2:0] CLK_DIV24 = 3'h3;
   localparam logic [2:0] CLK_DIV64 = 3'h4;
   localparam logic [2:0] CLK_EXT = 3'h5;
   localparam logic [2:0] CLK_RSVD = 3'h6;
   localparam logic [2:0] CLK_CHAIN = 3'h7;

   // edge treatment codes
   localparam logic [1:0] EDGE_BOTH = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_NONE = 2'h3;

   // mode bit values
   localparam logic MODE_DELAY = 1'b0;
   localparam logic MODE_COUNT = 1'b1;

   // prescaler divisors of the internal rc source
   localparam int NUM_DIV = 4;
   localparam int DIV_W = 7; // wide enough to hold 64 itself
   localparam logic [6:0] DIV_TAB [NUM_DIV] = '{7'h04, 7'h0c, 7'h18, 7'h40};

   // fixed extra ticks added to every delay, and reset-input filter length
   localparam logic [8:0] DLY_EXTRA = 9'h002;
   localparam logic [8:0] RST_FLT_LEN = 9'h002;

   // internal rc source frequency and its period in system clocks
   localparam int CLK_HZ = 40_000_000;
   localparam int RC_FREQ_HZ = 2_000_000;
   localparam int RC_DIV_CYC = CLK_HZ / RC_FREQ_HZ;
   localparam int RC_W = 16;

   // register byte offsets
   localparam logic [7:0] ADDR_CFG0 = 8'h00;
   localparam logic [7:0] ADDR_CFG1 = 8'h04;
   localparam logic [7:0] ADDR_CFG3 = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_COUNT0 = 8'h10;
   localparam logic [7:0] ADDR_COUNT1 = 8'h14;
   localparam logic [7:0] ADDR_COUNT3 = 8'h18;

   // reset value of every configuration: delay mode, rc clock, both edges
   localparam logic [13:0] CFG_RST = 14'h0000;

   // ahb transfer and response codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

endpackage

// *** rtl/ecd_unit.sv ***
/*
 * One counter/delay unit: an edge-selective delay filter on its delay/reset
 * input and an 8-bit reloading counter, both advanced by a one-cycle tick.
 * Assumes the tick, input and configuration are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ecd_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic din,
   input wire ecd_pkg::ecd_cfg_type cfg,
   output logic out,
   output logic rollover,
   output logic [7:0] count
);

   typedef struct packed {
      logic [8:0] flt_cnt;
      logic flt_out;
      logic [7:0] cnt;
      logic out;
      logic roll;
   } ecd_unit_st_type;

   ecd_unit_st_type s_r;
   ecd_unit_st_type s_nxt;
   logic [8:0] len;
   logic delayed;
   logic rst_lvl;

   // next-state logic for filter and counter
   always_comb begin
      s_nxt = s_r;
      s_nxt.roll = 1'b0;
      len = (cfg.mode == ecd_pkg::MODE_COUNT) ? ecd_pkg::RST_FLT_LEN : ({1'b0, cfg.ctrl} + ecd_pkg::DLY_EXTRA);
      case (cfg.edge_sel)
         ecd_pkg::EDGE_BOTH: delayed = 1'b1;
         ecd_pkg::EDGE_FALL: delayed = ~din;
         ecd_pkg::EDGE_RISE: delayed = din;
         default: delayed = 1'b0;
      endcase
      if (din == s_r.flt_out) begin
         s_nxt.flt_cnt = 9'h000; // a glitch shorter than the delay is dropped
      end else if (!delayed) begin
         s_nxt.flt_out = din;
         s_nxt.flt_cnt = 9'h000;
      end else if (tick) begin
         if (s_r.flt_cnt + 9'h001 >= len) begin
            s_nxt.flt_out = din;
            s_nxt.flt_cnt = 9'h000;
         end else begin
            s_nxt.flt_cnt = s_r.flt_cnt + 9'h001;
         end
      end
      // level reset when no edge is delayed
      rst_lvl = (cfg.edge_sel == ecd_pkg::EDGE_NONE) ? din : s_r.flt_out;
      if (cfg.mode == ecd_pkg::MODE_DELAY) begin
         s_nxt.out = s_nxt.flt_out;
         s_nxt.cnt = 8'h00;
      end else if (rst_lvl) begin
         s_nxt.cnt = 8'h00;
         s_nxt.out = 1'b0;
      end else if (tick) begin
         if (s_r.cnt >= cfg.ctrl) begin
            s_nxt.cnt = 8'h00;
            s_nxt.roll = 1'b1;
            s_nxt.out = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
            s_nxt.out = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign out = s_r.out;
   assign rollover = s_r.roll;
   assign count = s_r.cnt;

endmodule // ecd_unit

`default_nettype wire

// *** rtl/ecd_top.sv ***
/*
 * Three counter/delay units (zero, one, three) with their clock-source
 * selection, internal rc source and prescalers, and an AHB-Lite slave
 * holding the configuration and showing the unit state.
 * Assumes matrix inputs synchronous to CLOCK and a single AHB-Lite master.
 */
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
// What this block does
// - three independent 8-bit count/delay units numbered zero, one and three
// - a unit may be clocked by the preceding unit's rollover output
// - units zero and one take a delay/reset input and a separate external clock
// - unit three has one input: delay input, or external clock in counter mode
// - mode bit per unit: cleared selects delay, set selects counter
// - clock codes: rc, rc/4, rc/12, rc/24, rc/64, external; 110 reserved
// - unit zero code 111 clocks from unit three rollover
// - unit one code 111 clocks from unit zero rollover
// - control value sets length; delay is control plus two clock periods
// - edge code delays both, falling only, or rising only edges
// - edge code 11 passes edges; in counter mode high input clears count
// - unit three codes 110 and 111 are reserved, no chaining source
`timescale 1ns/1ps
`default_nettype none

module ecd_top #(
   parameter int RC_DIV = ecd_pkg::RC_DIV_CYC
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic DELAY_IN0,
   input wire logic EXT_CLK0,
   input wire logic DELAY_IN1,
   input wire logic EXT_CLK1,
   input wire logic SHARED_IN3,
   output logic UNIT0_OUT,
   output logic UNIT1_OUT,
   output logic UNIT3_OUT
);

   localparam int NU = 3; // index 2 holds unit three

   typedef struct packed {
      ecd_pkg::ecd_cfg_type [NU-1:0] cfg;
      logic [ecd_pkg::RC_W-1:0] rc_cnt;
      logic rc_tick;
      logic [ecd_pkg::NUM_DIV-1:0][ecd_pkg::DIV_W-1:0] div_cnt;
      logic [NU-1:0] ext_prev;
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
      logic [31:0] hrdata;
      logic hreadyout;
   } ecd_top_st_type;

   ecd_top_st_type s_r;
   ecd_top_st_type s_nxt;

   logic [ecd_pkg::NUM_DIV-1:0] div_tick;
   logic [NU-1:0] ext_in;
   logic [NU-1:0] ext_tick;
   logic [NU-1:0] din;
   logic [NU-1:0] chain_tick;
   logic [NU-1:0] unit_tick;
   logic [NU-1:0] unit_out;
   logic [NU-1:0] unit_roll;
   logic [NU-1:0][7:0] unit_cnt;
   logic [31:0] rd_word;
   logic addr_take;

   // separate external clocks for units zero and one
   assign ext_in[0] = EXT_CLK0;
   assign ext_in[1] = EXT_CLK1;
   // shared input is the external clock of unit three
   assign ext_in[2] = SHARED_IN3;

   // delay/reset inputs; unit three has no reset in counter mode
   assign din[0] = DELAY_IN0;
   assign din[1] = DELAY_IN1;
   // shared input is the delay input only in delay mode
   assign din[2] = (s_r.cfg[2].mode == ecd_pkg::MODE_DELAY) ? SHARED_IN3 : 1'b0;

   // external clocks count on their rising edge
   assign ext_tick = ext_in & ~s_r.ext_prev;

   // unit zero chains from unit three rollover
   assign chain_tick[0] = unit_roll[2];
   // unit one chains from unit zero rollover
   assign chain_tick[1] = unit_roll[0];
   // unit three has no chaining source
   assign chain_tick[2] = 1'b0;

   // prescaler taps, each a one-cycle pulse on a divided rc tick
   genvar gd;
   generate
      for (gd = 0; gd < ecd_pkg::NUM_DIV; gd++) begin : g_div
         assign div_tick[gd] = s_r.rc_tick && (s_r.div_cnt[gd] == ecd_pkg::DIV_TAB[gd] - 7'h01);
      end
   endgenerate

   // per-unit clock selection and the unit itself
   genvar gu;
   generate
      for (gu = 0; gu < NU; gu++) begin : g_unit
         logic tick_sel;
         // clock source decode, one local variable per unit
         always_comb begin
            case (s_r.cfg[gu].clk_sel)
               ecd_pkg::CLK_RC: tick_sel = s_r.rc_tick;
               ecd_pkg::CLK_DIV4: tick_sel = div_tick[0];
               ecd_pkg::CLK_DIV12: tick_sel = div_tick[1];
               ecd_pkg::CLK_DIV24: tick_sel = div_tick[2];
               ecd_pkg::CLK_DIV64: tick_sel = div_tick[3];
               // external clock ignored in delay mode
               ecd_pkg::CLK_EXT: tick_sel = ext_tick[gu] && (s_r.cfg[gu].mode == ecd_pkg::MODE_COUNT);
               ecd_pkg::CLK_CHAIN: tick_sel = chain_tick[gu];
               default: tick_sel = 1'b0; // reserved code stops the unit
            endcase
         end
         assign unit_tick[gu] = tick_sel;

         ecd_unit u_unit (
            .clk(CLOCK),
            .rst(SYS_RST),
            .tick(unit_tick[gu]),
            .din(din[gu]),
            .cfg(s_r.cfg[gu]),
            .out(unit_out[gu]),
            .rollover(unit_roll[gu]),
            .count(unit_cnt[gu])
         );
      end
   endgenerate

   // an address phase is taken when selected, nonseq and the bus is ready
   assign addr_take = HSEL && (HTRANS == ecd_pkg::HTRANS_NONSEQ) && HREADY;

   // read multiplexer, unmapped offsets read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (HADDR[7:0])
         ecd_pkg::ADDR_CFG0: rd_word[ecd_pkg::CFG_W-1:0] = s_r.cfg[0];
         ecd_pkg::ADDR_CFG1: rd_word[ecd_pkg::CFG_W-1:0] = s_r.cfg[1];
         ecd_pkg::ADDR_CFG3: rd_word[ecd_pkg::CFG_W-1:0] = s_r.cfg[2];
         ecd_pkg::ADDR_STATUS: rd_word[5:0] = {unit_roll, unit_out};
         ecd_pkg::ADDR_COUNT0: rd_word[7:0] = unit_cnt[0];
         ecd_pkg::ADDR_COUNT1: rd_word[7:0] = unit_cnt[1];
         ecd_pkg::ADDR_COUNT3: rd_word[7:0] = unit_cnt[2];
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // next state: rc source, prescalers, edge history and bus slave
   always_comb begin
      s_nxt = s_r;
      s_nxt.hreadyout = 1'b1;
      // internal rc source derived from the system clock
      s_nxt.rc_tick = 1'b0;
      if (s_r.rc_cnt >= ecd_pkg::RC_W'(RC_DIV - 1)) begin
         s_nxt.rc_cnt = '0;
         s_nxt.rc_tick = 1'b1;
      end else begin
         s_nxt.rc_cnt = s_r.rc_cnt + ecd_pkg::RC_W'(1);
      end
      // prescaler counters advance on each rc tick
      for (int k = 0; k < ecd_pkg::NUM_DIV; k++) begin
         if (s_r.rc_tick) begin
            if (div_tick[k]) begin
               s_nxt.div_cnt[k] = 7'h00;
            end else begin
               s_nxt.div_cnt[k] = s_r.div_cnt[k] + 7'h01;
            end
         end
      end
      s_nxt.ext_prev = ext_in;
      // data phase of a write stores the configuration
      if (s_r.ph_valid && s_r.ph_write) begin
         case (s_r.ph_addr)
            // mode, clock, control and edge bits of each unit
            ecd_pkg::ADDR_CFG0: s_nxt.cfg[0] = HWDATA[ecd_pkg::CFG_W-1:0];
            ecd_pkg::ADDR_CFG1: s_nxt.cfg[1] = HWDATA[ecd_pkg::CFG_W-1:0];
            ecd_pkg::ADDR_CFG3: s_nxt.cfg[2] = HWDATA[ecd_pkg::CFG_W-1:0];
            default: s_nxt.cfg = s_r.cfg; // read-only or unmapped
         endcase
      end
      // address phase: latch the transfer and stage read data
      s_nxt.ph_valid = addr_take;
      s_nxt.ph_write = addr_take && HWRITE;
      s_nxt.ph_addr = addr_take ? HADDR[7:0] : 8'h00;
      if (addr_take && !HWRITE) begin
         s_nxt.hrdata = rd_word;
      end
   end

   // state register
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         s_r.cfg <= {NU{ecd_pkg::CFG_RST}};
         s_r.rc_cnt <= '0;
         s_r.rc_tick <= 1'b0;
         s_r.div_cnt <= '0;
         s_r.ext_prev <= '0;
         s_r.ph_valid <= 1'b0;
         s_r.ph_write <= 1'b0;
         s_r.ph_addr <= 8'h00;
         s_r.hrdata <= 32'h0000_0000;
         s_r.hreadyout <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs, each taken from a flip-flop except HRESP, which is tied to OKAY
   assign HRDATA = s_r.hrdata;
   assign HREADYOUT = s_r.hreadyout;
   assign HRESP = ecd_pkg::HRESP_OKAY;
   assign UNIT0_OUT = unit_out[0];
   assign UNIT1_OUT = unit_out[1];
   assign UNIT3_OUT = unit_out[2];

endmodule // ecd_top

`default_nettype wire

// *** bench/ecd_chk.sv ***
/* Checker for ecd_top: bus answers, read-back, unit zero no-delay path.
   Assumes it is bound to ecd_top with one AHB-Lite master. */
`timescale 1ns/1ps
`default_nettype none
module ecd_chk #(
   parameter int RC_DIV = ecd_pkg::RC_DIV_CYC
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic DELAY_IN0,
   input wire logic UNIT0_OUT,
   input wire logic UNIT1_OUT,
   input wire logic UNIT3_OUT
);
   logic rd;
   logic clr0;
   logic wr_p;
   logic [7:0] wa;
   logic [13:0] c0;
   // read taken; unit zero held in level clear
   assign rd = HSEL && HREADY && HTRANS == ecd_pkg::HTRANS_NONSEQ && !HWRITE;
   assign clr0 = c0[0] && c0[13:12] == 2'h3 && DELAY_IN0;
   // shadow of the unit zero configuration
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         wr_p <= 1'b0;
         wa <= 8'h00;
         c0 <= 14'h0000;
      end else begin
         wr_p <= HSEL && HREADY && HTRANS == ecd_pkg::HTRANS_NONSEQ && HWRITE;
         wa <= HADDR[7:0];
         if (wr_p && wa == ecd_pkg::ADDR_CFG0) c0 <= HWDATA[13:0];
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   ready_high_a: assert property (HREADYOUT) else $error("wait state");
   resp_okay_a: assert property (HRESP == ecd_pkg::HRESP_OKAY) else $error("bad response");
   reset_clear_a: assert property ($fell(SYS_RST) |-> !UNIT0_OUT && !UNIT1_OUT && !UNIT3_OUT && HRDATA == 32'h0)
      else $error("not cleared");
   unmapped_zero_a: assert property (rd && HADDR[7:0] > 8'h18 |=> HRDATA == 32'h0) else $error("unmapped");
   count_width_a: assert property (rd && HADDR[7:0] >= 8'h10 && HADDR[7:0] <= 8'h18 |=> HRDATA[31:8] == 24'h0)
      else $error("count width");
   cfg_width_a: assert property (rd && HADDR[7:0] < 8'h0c |=> HRDATA[31:14] == 18'h0) else $error("cfg width");
   cfg_readback_a: assert property (rd && HADDR[7:0] == 8'h00 |=> HRDATA[13:0] == c0) else $error("cfg0 read");
   rdata_hold_a: assert property (!rd |=> $stable(HRDATA)) else $error("read data moved");
   follow_in_a: assert property (!c0[0] && c0[13:12] == 2'h3 && $rose(DELAY_IN0) |-> ##[1:2] UNIT0_OUT)
      else $error("no-delay path late");
   clear_out_a: assert property (clr0 [*3] |-> !UNIT0_OUT) else $error("clear ignored");
endmodule // ecd_chk
`default_nettype wire

// *** bench/ecd_mtx.sv ***
/* Matrix-side model: drives the five unit inputs as levels and pulses.
   Assumes one system clock; pins are {shared3, ext1, din1, ext0, din0}. */
`timescale 1ns/1ps
`default_nettype none
module ecd_mtx (
   input wire logic clk,
   output logic [4:0] pins
);
   // all inputs low at start
   initial pins = 5'h00;
   task set_pin(input int k, input logic v);
      @(posedge clk);
      pins[k] <= v;
   endtask
   // clock pulses, two cycles high, two low
   task pulse(input int k, input int n);
      repeat (n) begin
         set_pin(k, 1'b1);
         @(posedge clk);
         set_pin(k, 1'b0);
         @(posedge clk);
      end
   endtask
endmodule // ecd_mtx
`default_nettype wire

// *** bench/tb.sv ***
/* Self-checking bench for ecd_top: registers, delay, counter, chaining,
   external clocks, level clear and reserved codes. Assumes ecd_mtx. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int RCD = 2;
   logic CLOCK = 1'b0;
   logic SYS_RST = 1'b1;
   logic HSEL = 1'b0;
   logic HWRITE = 1'b0;
   logic [1:0] HTRANS = 2'h0;
   logic [31:0] HADDR = 32'h0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA;
   logic HREADYOUT, HRESP, UNIT0_OUT, UNIT1_OUT, UNIT3_OUT;
   wire logic [4:0] pins;
   wire logic [2:0] outs = {UNIT3_OUT, UNIT1_OUT, UNIT0_OUT};
   int n_mismatch = 0;
   int samples_checked = 0;
   int seed = 32'h0a5bcc6a;
   int dv[5] = '{1, 4, 12, 24, 64};
   int i, k, n, c, e;
   int cv[3];
   // 40 MHz clock
   always #12.5 CLOCK = ~CLOCK;
   ecd_top #(.RC_DIV(RCD)) i_ecd_top (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DELAY_IN0(pins[0]), .EXT_CLK0(pins[1]), .DELAY_IN1(pins[2]),
      .EXT_CLK1(pins[3]), .SHARED_IN3(pins[4]), .UNIT0_OUT(UNIT0_OUT), .UNIT1_OUT(UNIT1_OUT), .UNIT3_OUT(UNIT3_OUT));
   ecd_mtx i_ecd_mtx (.clk(CLOCK), .pins(pins));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task conclude;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one single AHB-Lite transfer, waits for ready in both phases
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge CLOCK);
      HSEL <= 1'b1;
      HTRANS <= ecd_pkg::HTRANS_NONSEQ;
      HWRITE <= w;
      HADDR <= {24'h0, a};
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check("register", q, exp);
   endtask
   task automatic do_reset;
      @(posedge CLOCK);
      SYS_RST <= 1'b1;
      repeat (5) @(posedge CLOCK);
      SYS_RST <= 1'b0;
   endtask
   function automatic logic [31:0] cfgw(input logic m, input logic [2:0] k, input logic [7:0] c, input logic [1:0] e);
      return {18'h0, e, c, k, m};
   endfunction
   // expected latency window of a delayed or a passed edge
   function automatic logic lat_ok(input logic dly, input int c, input int n);
      if (dly) return n >= (c + 1) * RCD + 1 && n <= (c + 3) * RCD + 3;
      return n >= 2 && n <= 3;
   endfunction
   // cycles from an input change until the unit output follows
   task automatic lat(input int u, input logic v, output int n);
      i_ecd_mtx.set_pin(2 * u, v);
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (outs[u] !== v && n < 200);
   endtask
   // period between output rises and high time in between
   task automatic ctr(input int u, input int per, input int hi);
      int r1 = -1;
      int p = -1;
      int h = 0;
      int n = 0;
      logic last = 1'b1;
      while (p < 0 && n < 4000) begin
         @(posedge CLOCK);
         n++;
         if (outs[u] === 1'b1 && last === 1'b0) begin
            if (r1 >= 0) p = n - r1;
            else r1 = n;
         end
         if (r1 >= 0 && p < 0 && outs[u] === 1'b1) h++;
         last = outs[u];
      end
      check("period", p, per);
      check("width", h, hi);
   endtask
   // main sequence
   initial begin
      logic [31:0] w;
      do_reset;
      for (i = 0; i < 8; i++) rd_chk(8'(4 * i), 32'h0);
      for (i = 0; i < 3; i++) begin
         w = $random(seed) & 32'h3fff;
         // external clock only in counter mode
         w[0] = w[0] | (w[3:1] == 3'h5);
         wr(8'(4 * i), w | 32'hffffc000);
         rd_chk(8'(4 * i), w);
      end
      wr(8'h1c, 32'hffffffff);
      rd_chk(8'h1c, 32'h0);
      do_reset;
      for (i = 0; i < 3; i++) begin
         for (e = 0; e < 4; e++) begin
            c = 1 + ($random(seed) & 3);
            wr(8'(4 * i), cfgw(1'b0, 3'h0, 8'(c), 2'(e)));
            lat(i, 1'b1, n);
            check("rise", lat_ok(e == 0 || e == 2, c, n), 1'b1);
            lat(i, 1'b0, n);
            check("fall", lat_ok(e < 2, c, n), 1'b1);
         end
      end
      for (k = 0; k < 5; k++) begin
         do_reset;
         c = 1 + ($random(seed) & 3);
         wr(8'h00, cfgw(1'b1, 3'(k), 8'(c), 2'h0));
         ctr(0, (c + 1) * RCD * dv[k], RCD * dv[k]);
      end
      do_reset;
      for (i = 0; i < 3; i++) cv[i] = 1 + ($random(seed) & 3);
      wr(8'h08, cfgw(1'b1, 3'h0, 8'(cv[2]), 2'h0));
      wr(8'h00, cfgw(1'b1, 3'h7, 8'(cv[0]), 2'h0));
      wr(8'h04, cfgw(1'b1, 3'h7, 8'(cv[1]), 2'h0));
      ctr(0, (cv[0] + 1) * (cv[2] + 1) * RCD, (cv[2] + 1) * RCD);
      ctr(1, (cv[1] + 1) * (cv[0] + 1) * (cv[2] + 1) * RCD, (cv[0] + 1) * (cv[2] + 1) * RCD);
      do_reset;
      for (i = 0; i < 3; i++) begin
         n = 1 + ($random(seed) & 3);
         wr(8'(4 * i), cfgw(1'b1, 3'h5, 8'h07, 2'h0));
         i_ecd_mtx.pulse(i == 2 ? 4 : 2 * i + 1, n);
         repeat (4) @(posedge CLOCK);
         rd_chk(8'(8'h10 + 4 * i), 32'(n));
      end
      wr(8'h00, cfgw(1'b1, 3'h5, 8'h07, 2'h3));
      i_ecd_mtx.set_pin(0, 1'b1);
      i_ecd_mtx.pulse(1, 2);
      rd_chk(8'h10, 32'h0);
      i_ecd_mtx.set_pin(0, 1'b0);
      repeat (2) @(posedge CLOCK);
      i_ecd_mtx.pulse(1, 2);
      repeat (4) @(posedge CLOCK);
      rd_chk(8'h10, 32'h2);
      for (k = 6; k < 8; k++) begin
         do_reset;
         wr(8'h08, cfgw(1'b1, 3'(k), 8'h00, 2'h0));
         wr(8'h00, cfgw(1'b1, 3'h6, 8'h00, 2'h0));
         repeat (50) @(posedge CLOCK);
         rd_chk(8'h18, 32'h0);
         rd_chk(8'h10, 32'h0);
      end
      conclude;
   end
   // cut a hang short
   initial begin
      repeat (60000) @(posedge CLOCK);
      n_mismatch++;
      conclude;
   end
endmodule // tb
bind ecd_top ecd_chk #(.RC_DIV(RC_DIV)) i_ecd_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .DELAY_IN0(DELAY_IN0), .UNIT0_OUT(UNIT0_OUT), .UNIT1_OUT(UNIT1_OUT), .UNIT3_OUT(UNIT3_OUT));
`default_nettype wire
